// ---- rtl/sdmld_pkg.sv ----
// Constants, types and register map of the surface descriptor decoder.
`default_nettype none
// How it works
// - Storage-format bit 6: 0 render-target layout, 1 depth-or-stencil layout.
// - Storage format is ignored when the sample count is one.
// - Sample count bits 5:3: 0 one, 2 four, 3 eight; others reserved.
// - Structured buffers add minimum array element bits 26:0 to the index.
// - Palette index bits 2:0 is returned in the sample reply only to sample-info requests.
// - Horizontal origin bits 31:25 count pixels in fours, 0 to 508.
// - Packed 4:2:2 surfaces count the horizontal offset in twos.
// - Vertical origin bits 23:20 count rows in twos, 0 to 30.
// - Minimum LOD bits 7:4 adds to explicit-LOD, load and resinfo LOD.
// - Mip bits 3:0 give level count minus one, or render-target level.
// - With control surface on, bits 31:12 give its 4 KB aligned base.
// - The control surface shares size, LOD, mip and array settings.
// - With control surface and format A off, bits 31:6 give the append counter base.
// - Control-surface pitch bits 11:3 is tiles minus one.
// - Without format A, enable bit 0 gates control-surface fields, else append address applies.
package sdmld_pkg;
   // *****************************************************************
   // Register map.
   // *****************************************************************
   localparam logic [7:0] ADDR_MS_WORD = 8'h00;
   localparam logic [7:0] ADDR_ORIGIN_WORD = 8'h04;
   localparam logic [7:0] ADDR_AUX_WORD = 8'h08;
   localparam logic [7:0] ADDR_CONTROL = 8'h0C;
   localparam logic [7:0] ADDR_REQ_LOD = 8'h10;
   localparam logic [7:0] ADDR_REQ_INDEX = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_OFFSETS = 8'h1C;
   localparam logic [7:0] ADDR_LOD_RESULT = 8'h20;
   localparam logic [7:0] ADDR_INDEX_RESULT = 8'h24;
   localparam logic [7:0] ADDR_AUX_ADDR = 8'h28;
   localparam logic [7:0] ADDR_AUX_INFO = 8'h2C;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   // *****************************************************************
   // Descriptor field positions.
   // *****************************************************************
   localparam int FMT_BIT = 6;
   localparam int CNT_LSB = 3;
   localparam int PAL_LSB = 0;
   localparam int MINARR_MSB = 26;
   localparam int XOFF_LSB = 25;
   localparam int YOFF_LSB = 20;
   localparam int MINLOD_LSB = 4;
   localparam int MIP_LSB = 0;
   localparam int MCS_EN_BIT = 0;
   localparam int APPEND_EN_BIT = 1;
   localparam int MCS_BASE_LSB = 12;
   localparam int APPEND_LSB = 6;
   localparam int MCS_PITCH_LSB = 3;
   localparam int UVX_LSB = 16;
   localparam int UVY_LSB = 0;
   // *****************************************************************
   // Control register layout.
   // *****************************************************************
   localparam int CTRL_STRBUF_BIT = 0;
   localparam int CTRL_RT_BIT = 1;
   localparam int CTRL_FORMAT_A_BIT = 2;
   localparam int CTRL_422_BIT = 3;
   localparam int CTRL_KIND_LSB = 4;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   // *****************************************************************
   // Encodings.
   // *****************************************************************
   localparam logic [2:0] samples_one = 3'h0;
   localparam logic [2:0] samples_four = 3'h2;
   localparam logic [2:0] samples_eight = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {layout_render_target, layout_depth_stencil}
      sdmld_layout_e;
   typedef enum logic [2:0] {req_sample, req_explicit_lod, req_load,
      req_resinfo, req_sampleinfo, req_multisample_texel_load} sdmld_req_e;
endpackage
`default_nettype wire

// ---- rtl/sdmld_fields_if.sv ----
// Decoded descriptor fields passed between decoder and resolver.
`timescale 1ns/1ps
`default_nettype none
interface sdmld_fields_if;
   logic [3:0] samples;
   logic count_reserved;
   sdmld_pkg::sdmld_layout_e layout;
   logic [2:0] palette;
   logic [26:0] min_array;
   logic [8:0] x_pixels;
   logic [4:0] y_rows;
   logic [3:0] min_lod;
   logic [3:0] mip;
   logic mcs_enable;
   logic [31:0] mcs_base;
   logic [9:0] mcs_pitch_tiles;
   logic append_enable;
   logic [31:0] append_addr;
   logic [13:0] uv_x;
   logic [13:0] uv_y;
   modport producer(output samples, count_reserved, layout, palette,
      min_array, x_pixels, y_rows, min_lod, mip, mcs_enable, mcs_base,
      mcs_pitch_tiles, append_enable, append_addr, uv_x, uv_y);
   modport consumer(input samples, count_reserved, layout, palette,
      min_array, x_pixels, y_rows, min_lod, mip, mcs_enable, mcs_base,
      mcs_pitch_tiles, append_enable, append_addr, uv_x, uv_y);
endinterface
`default_nettype wire

// ---- rtl/sdmld_decode.sv ----
// Registered decode of the three descriptor words into fields.
`timescale 1ns/1ps
`default_nettype none
module sdmld_decode (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Descriptor words and surface kind.
   input wire logic [31:0] ms_word,
   input wire logic [31:0] origin_word,
   input wire logic [31:0] aux_word,
   input wire logic strbuf,
   input wire logic format_a,
   input wire logic packed_422_chroma,
   // Decoded fields.
   sdmld_fields_if.producer fields
);
   wire logic [2:0] cnt_code = ms_word[sdmld_pkg::CNT_LSB +: 3];
   wire logic multi = !strbuf && (cnt_code != sdmld_pkg::samples_one);
   wire logic [3:0] next_samples =
      (cnt_code == sdmld_pkg::samples_four) ? 4'h4 :
      (cnt_code == sdmld_pkg::samples_eight) ? 4'h8 : 4'h1;
   wire logic next_reserved = !strbuf &&
      (cnt_code != sdmld_pkg::samples_one) &&
      (cnt_code != sdmld_pkg::samples_four) &&
      (cnt_code != sdmld_pkg::samples_eight);
   wire logic [6:0] xoff = origin_word[sdmld_pkg::XOFF_LSB +: 7];
   wire logic mcs_on = !format_a && aux_word[sdmld_pkg::MCS_EN_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fields.samples <= 4'h1;
         fields.count_reserved <= 1'b0;
         fields.layout <= sdmld_pkg::layout_render_target;
         fields.palette <= 3'h0;
         fields.min_array <= 27'h000_0000;
         fields.x_pixels <= 9'h000;
         fields.y_rows <= 5'h00;
         fields.min_lod <= 4'h0;
         fields.mip <= 4'h0;
         fields.mcs_enable <= 1'b0;
         fields.mcs_base <= 32'h0000_0000;
         fields.mcs_pitch_tiles <= 10'h001;
         fields.append_enable <= 1'b0;
         fields.append_addr <= 32'h0000_0000;
         fields.uv_x <= 14'h0000;
         fields.uv_y <= 14'h0000;
      end else begin
         fields.samples <= strbuf ? 4'h1 : next_samples;
         fields.count_reserved <= next_reserved;
         fields.layout <= (multi && ms_word[sdmld_pkg::FMT_BIT]) ?
            sdmld_pkg::layout_depth_stencil :
            sdmld_pkg::layout_render_target;
         fields.palette <= strbuf ? 3'h0 :
            ms_word[sdmld_pkg::PAL_LSB +: 3];
         fields.min_array <= strbuf ?
            ms_word[sdmld_pkg::MINARR_MSB:0] : 27'h000_0000;
         fields.x_pixels <= packed_422_chroma ?
            {1'b0, xoff, 1'b0} : {xoff, 2'b00};
         fields.y_rows <= {origin_word[sdmld_pkg::YOFF_LSB +: 4], 1'b0};
         fields.min_lod <= origin_word[sdmld_pkg::MINLOD_LSB +: 4];
         fields.mip <= origin_word[sdmld_pkg::MIP_LSB +: 4];
         fields.mcs_enable <= mcs_on;
         fields.mcs_base <= mcs_on ?
            {aux_word[31:sdmld_pkg::MCS_BASE_LSB], 12'h000} :
            32'h0000_0000;
         fields.mcs_pitch_tiles <= mcs_on ?
            {1'b0, aux_word[sdmld_pkg::MCS_PITCH_LSB +: 9]} + 10'h001 :
            10'h001;
         fields.append_enable <= !format_a && !mcs_on &&
            aux_word[sdmld_pkg::APPEND_EN_BIT];
         fields.append_addr <= (!format_a && !mcs_on) ?
            {aux_word[31:sdmld_pkg::APPEND_LSB], 6'h00} :
            32'h0000_0000;
         fields.uv_x <= format_a ? aux_word[sdmld_pkg::UVX_LSB +: 14] :
            14'h0000;
         fields.uv_y <= format_a ? aux_word[sdmld_pkg::UVY_LSB +: 14] :
            14'h0000;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/sdmld_resolve.sv ----
// Applies decoded fields to one sampling request.
`timescale 1ns/1ps
`default_nettype none
module sdmld_resolve (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Request and surface kind.
   input wire sdmld_pkg::sdmld_req_e kind,
   input wire logic [3:0] req_lod,
   input wire logic [26:0] req_index,
   input wire logic render_target,
   // Decoded fields.
   sdmld_fields_if.consumer fields,
   // Results.
   output logic [26:0] eff_index,
   output logic [4:0] eff_lod,
   output logic [4:0] last_lod,
   output logic [2:0] sample_reply,
   output logic kind_violation,
   output logic lod_violation
);
   wire logic lod_kind = (kind == sdmld_pkg::req_explicit_lod) ||
      (kind == sdmld_pkg::req_load) || (kind == sdmld_pkg::req_resinfo);
   wire logic ds_ok = (kind == sdmld_pkg::req_multisample_texel_load) ||
      (kind == sdmld_pkg::req_resinfo) ||
      (kind == sdmld_pkg::req_sampleinfo);
   wire logic multi = fields.samples != 4'h1;

   // The control surface uses these same index and LOD results.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eff_index <= 27'h000_0000;
         eff_lod <= 5'h00;
         last_lod <= 5'h00;
         sample_reply <= 3'h0;
         kind_violation <= 1'b0;
         lod_violation <= 1'b0;
      end else begin
         eff_index <= req_index + fields.min_array;
         if (render_target) begin
            eff_lod <= {1'b0, fields.mip};
            last_lod <= {1'b0, fields.mip};
         end else begin
            eff_lod <= lod_kind ?
               {1'b0, req_lod} + {1'b0, fields.min_lod} :
               {1'b0, fields.min_lod};
            last_lod <= {1'b0, fields.min_lod} + {1'b0, fields.mip};
         end
         sample_reply <= (kind == sdmld_pkg::req_sampleinfo) ?
            fields.palette : 3'h0;
         kind_violation <= (fields.layout ==
            sdmld_pkg::layout_depth_stencil) && !ds_ok;
         lod_violation <= multi &&
            ((fields.min_lod != 4'h0) || (fields.mip != 4'h0));
      end
   end
endmodule
`default_nettype wire

// ---- rtl/sdmld_top.sv ----
// Descriptor decoder with its AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
module sdmld_top (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel.
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // *****************************************************************
   // Register storage.
   // *****************************************************************
   logic [31:0] ms_word;
   logic [31:0] origin_word;
   logic [31:0] aux_word;
   logic [6:0] control;
   logic [3:0] req_lod;
   logic [26:0] req_index;

   // *****************************************************************
   // Write channel capture.
   // *****************************************************************
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;

   wire logic aw_take = s_axi_awvalid && s_axi_awready;
   wire logic w_take = s_axi_wvalid && s_axi_wready;
   wire logic do_write = aw_held && w_held;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // *****************************************************************
   // Write decode and byte-lane merge.
   // *****************************************************************
   wire logic [31:0] lane_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire logic wr_ms = do_write && (aw_addr_q == sdmld_pkg::ADDR_MS_WORD);
   wire logic wr_origin = do_write &&
      (aw_addr_q == sdmld_pkg::ADDR_ORIGIN_WORD);
   wire logic wr_aux = do_write && (aw_addr_q == sdmld_pkg::ADDR_AUX_WORD);
   wire logic wr_ctrl = do_write && (aw_addr_q == sdmld_pkg::ADDR_CONTROL);
   wire logic wr_lod = do_write && (aw_addr_q == sdmld_pkg::ADDR_REQ_LOD);
   wire logic wr_index = do_write &&
      (aw_addr_q == sdmld_pkg::ADDR_REQ_INDEX);
   wire logic wr_read_only = (aw_addr_q == sdmld_pkg::ADDR_STATUS) ||
      (aw_addr_q == sdmld_pkg::ADDR_OFFSETS) ||
      (aw_addr_q == sdmld_pkg::ADDR_LOD_RESULT) ||
      (aw_addr_q == sdmld_pkg::ADDR_INDEX_RESULT) ||
      (aw_addr_q == sdmld_pkg::ADDR_AUX_ADDR) ||
      (aw_addr_q == sdmld_pkg::ADDR_AUX_INFO);
   wire logic wr_hit = wr_ms || wr_origin || wr_aux || wr_ctrl || wr_lod ||
      wr_index || (do_write && wr_read_only);

   wire logic [31:0] ctrl_word = {25'h000_0000, control};
   wire logic [31:0] lod_word = {28'h000_0000, req_lod};
   wire logic [31:0] index_word = {5'h00, req_index};
   wire logic [31:0] next_ms = (ms_word & ~lane_mask) |
      (w_data_q & lane_mask);
   wire logic [31:0] next_origin = (origin_word & ~lane_mask) |
      (w_data_q & lane_mask);
   wire logic [31:0] next_aux = (aux_word & ~lane_mask) |
      (w_data_q & lane_mask);
   wire logic [31:0] next_ctrl = (ctrl_word & ~lane_mask) |
      (w_data_q & lane_mask);
   wire logic [31:0] next_lod = (lod_word & ~lane_mask) |
      (w_data_q & lane_mask);
   wire logic [31:0] next_index = (index_word & ~lane_mask) |
      (w_data_q & lane_mask);

   // Reserved descriptor bits are stored but never decoded.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_word <= sdmld_pkg::WORD_RESET;
         origin_word <= sdmld_pkg::WORD_RESET;
         aux_word <= sdmld_pkg::WORD_RESET;
         control <= sdmld_pkg::CTRL_RESET;
         req_lod <= 4'h0;
         req_index <= 27'h000_0000;
      end else begin
         if (wr_ms) ms_word <= next_ms;
         if (wr_origin) origin_word <= next_origin;
         if (wr_aux) aux_word <= next_aux;
         if (wr_ctrl) control <= next_ctrl[6:0];
         if (wr_lod) req_lod <= next_lod[3:0];
         if (wr_index) req_index <= next_index[26:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sdmld_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? sdmld_pkg::RESP_OKAY :
            sdmld_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // *****************************************************************
   // Decode and request resolution.
   // *****************************************************************
   sdmld_fields_if fields ();

   wire logic strbuf = control[sdmld_pkg::CTRL_STRBUF_BIT];
   wire logic render_target = control[sdmld_pkg::CTRL_RT_BIT];
   wire logic format_a = control[sdmld_pkg::CTRL_FORMAT_A_BIT];
   wire logic packed_422_chroma = control[sdmld_pkg::CTRL_422_BIT];
   wire sdmld_pkg::sdmld_req_e kind =
      sdmld_pkg::sdmld_req_e'(control[sdmld_pkg::CTRL_KIND_LSB +: 3]);

   sdmld_decode u_decode (
      .aclk(aclk),
      .aresetn(aresetn),
      .ms_word(ms_word),
      .origin_word(origin_word),
      .aux_word(aux_word),
      .strbuf(strbuf),
      .format_a(format_a),
      .packed_422_chroma(packed_422_chroma),
      .fields(fields)
   );

   logic [26:0] eff_index;
   logic [4:0] eff_lod;
   logic [4:0] last_lod;
   logic [2:0] sample_reply;
   logic kind_violation;
   logic lod_violation;

   sdmld_resolve u_resolve (
      .aclk(aclk),
      .aresetn(aresetn),
      .kind(kind),
      .req_lod(req_lod),
      .req_index(req_index),
      .render_target(render_target),
      .fields(fields),
      .eff_index(eff_index),
      .eff_lod(eff_lod),
      .last_lod(last_lod),
      .sample_reply(sample_reply),
      .kind_violation(kind_violation),
      .lod_violation(lod_violation)
   );

   // *****************************************************************
   // Read path.
   // *****************************************************************
   wire logic [31:0] status_word = {16'h0000, lod_violation,
      kind_violation, fields.append_enable, fields.mcs_enable,
      sample_reply, fields.palette, fields.layout,
      fields.count_reserved, fields.samples};
   wire logic [31:0] offsets_word = {11'h000, fields.y_rows, 7'h00,
      fields.x_pixels};
   wire logic [31:0] lod_result = {14'h0000, fields.mip, fields.min_lod,
      last_lod, eff_lod};
   wire logic [31:0] index_result = {5'h00, eff_index};
   wire logic [31:0] aux_addr = fields.mcs_enable ? fields.mcs_base :
      fields.append_addr;
   wire logic [31:0] aux_info = format_a ?
      {2'b00, fields.uv_x, 2'b00, fields.uv_y} :
      {22'h00_0000, fields.mcs_pitch_tiles};

   wire logic [7:0] ra = s_axi_araddr;
   wire logic rd_hit = (ra == sdmld_pkg::ADDR_MS_WORD) ||
      (ra == sdmld_pkg::ADDR_ORIGIN_WORD) ||
      (ra == sdmld_pkg::ADDR_AUX_WORD) || (ra == sdmld_pkg::ADDR_CONTROL) ||
      (ra == sdmld_pkg::ADDR_REQ_LOD) || (ra == sdmld_pkg::ADDR_REQ_INDEX) ||
      (ra == sdmld_pkg::ADDR_STATUS) || (ra == sdmld_pkg::ADDR_OFFSETS) ||
      (ra == sdmld_pkg::ADDR_LOD_RESULT) ||
      (ra == sdmld_pkg::ADDR_INDEX_RESULT) ||
      (ra == sdmld_pkg::ADDR_AUX_ADDR) || (ra == sdmld_pkg::ADDR_AUX_INFO);
   wire logic [31:0] rd_data =
      (ra == sdmld_pkg::ADDR_MS_WORD) ? ms_word :
      (ra == sdmld_pkg::ADDR_ORIGIN_WORD) ? origin_word :
      (ra == sdmld_pkg::ADDR_AUX_WORD) ? aux_word :
      (ra == sdmld_pkg::ADDR_CONTROL) ? ctrl_word :
      (ra == sdmld_pkg::ADDR_REQ_LOD) ? lod_word :
      (ra == sdmld_pkg::ADDR_REQ_INDEX) ? index_word :
      (ra == sdmld_pkg::ADDR_STATUS) ? status_word :
      (ra == sdmld_pkg::ADDR_OFFSETS) ? offsets_word :
      (ra == sdmld_pkg::ADDR_LOD_RESULT) ? lod_result :
      (ra == sdmld_pkg::ADDR_INDEX_RESULT) ? index_result :
      (ra == sdmld_pkg::ADDR_AUX_ADDR) ? aux_addr :
      (ra == sdmld_pkg::ADDR_AUX_INFO) ? aux_info : 32'h0000_0000;

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= sdmld_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_hit ? sdmld_pkg::RESP_OKAY :
            sdmld_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- test/sdmld_properties.sv ----
// Bus handshake checker for the descriptor decoder.
`timescale 1ns/1ps
`default_nettype none
module sdmld_properties (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus signals.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bresp_holds:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_holds:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   a_bvalid_blocks:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
   a_rvalid_blocks:
   assert property (s_axi_arready != s_axi_rvalid)
      else $error("read ready wrong");
   a_write_answer:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write reply");
   a_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late read reply");
   a_read_unmapped:
   assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2F
      |=> s_axi_rresp == sdmld_pkg::RESP_SLVERR && s_axi_rdata == 0)
      else $error("unmapped read not refused");
   a_write_unmapped:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr > 8'h2F
      |-> ##2 s_axi_bresp == sdmld_pkg::RESP_SLVERR)
      else $error("unmapped write not refused");
   a_reply_release:
   assert property (s_axi_rvalid && s_axi_rready || s_axi_bvalid
      && s_axi_bready |=> !s_axi_rvalid || !s_axi_bvalid)
      else $error("reply not released");
endmodule
bind sdmld_top sdmld_properties u_props (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ---- test/sdmld_top_test.sv ----
// Self-checking bench for the descriptor decoder.
`timescale 1ns/1ps
`default_nettype none
module sdmld_top_test;
   logic aclk, aresetn, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd;
   logic [1:0] br, rr;
   int bad_count = 0, checks_done = 0, cyc = 0;
   sdmld_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e = 2'h0);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wr_r) wv <= 0;
      end while (!bv);
      bry <= 0;
      chk("bresp", 32'(br), 32'(e));
      @(posedge aclk);
   endtask
   task automatic rdc(string n, logic [7:0] a, logic [31:0] m,
         logic [31:0] e, logic [1:0] er = 2'h0);
      repeat (3) @(posedge aclk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end while (!rv);
      rry <= 0;
      chk(n, rd & m, e);
      chk("rresp", 32'(rr), 32'(er));
   endtask
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_count();
      logic [31:0] e;
      wr(8'h0C, 32'h0000_0030);
      for (int c = 0; c < 8; c++) begin
         wr(8'h00, {25'h0, 1'b1, c[2:0], 3'h5});
         e = {20'h0, 3'h0, 3'h5, c != 0, !(c inside {0, 2, 3}),
            c == 2 ? 4'h4 : c == 3 ? 4'h8 : 4'h1};
         rdc("status", 8'h18, '1, e);
      end
      wr(8'h0C, 32'h0000_0040);
      rdc("reply", 8'h18, 32'h0000_0E00, 32'h0000_0A00);
      wr(8'h00, 32'h0000_0050);
      wr(8'h0C, 32'h0000_0000);
      rdc("kind", 8'h18, '1, 32'h0000_4024);
   endtask
   task automatic t_origin();
      wr(8'h04, 32'hFEF0_0000);
      rdc("offsets", 8'h1C, '1, 32'h001E_01FC);
      wr(8'h0C, 32'h0000_0008);
      rdc("offsets", 8'h1C, '1, 32'h001E_00FE);
   endtask
   task automatic t_lod();
      wr(8'h04, 32'h0000_0035);
      wr(8'h10, 32'h0000_0004);
      for (int k = 0; k < 4; k++) begin
         wr(8'h0C, k << 4);
         rdc("lod", 8'h20, '1,
            k != 0 ? 32'h0001_4D07 : 32'h0001_4D03);
      end
      rdc("lodflag", 8'h18, 32'h0000_C000, 32'h0000_8000);
      wr(8'h0C, 32'h0000_0012);
      rdc("lod", 8'h20, 32'h0000_001F, 32'h0000_0005);
   endtask
   task automatic t_index();
      wr(8'h00, 32'h0000_0064);
      wr(8'h14, 32'h07FF_FFF0);
      wr(8'h0C, 32'h0000_0001);
      rdc("index", 8'h24, '1, 32'h0000_0054);
      wr(8'h0C, 32'h0000_0000);
      rdc("index", 8'h24, '1, 32'h07FF_FFF0);
   endtask
   task automatic t_aux();
      wr(8'h08, 32'hABCD_EFF9);
      rdc("aux", 8'h28, '1, 32'hABCD_E000);
      rdc("pitch", 8'h2C, '1, 32'h0000_0200);
      wr(8'h08, 32'h1234_5682);
      rdc("append", 8'h28, '1, 32'h1234_5680);
      rdc("enables", 8'h18, 32'h0000_3000, 32'h0000_2000);
      wr(8'h0C, 32'h0000_0004);
      rdc("format_a", 8'h2C, '1, 32'h1234_1682);
      wr(8'h30, 32'h0000_0001, 2'h2);
      rdc("unmapped", 8'h30, '1, 32'h0000_0000, 2'h2);
   endtask
   initial begin
      {aresetn, awv, wv, bry, arv, rry} = '0;
      {awa, ara, wd} = '0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rdc("status", 8'h18, '1, 32'h0000_0001);
      rdc("pitch", 8'h2C, '1, 32'h0000_0001);
      t_count();
      t_origin();
      t_lod();
      t_index();
      t_aux();
      close_out();
   end
endmodule
`default_nettype wire
